/* File: hw/pwm_timer_defines.svh */
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH

// Register byte offsets
`define OFS_CLOCK_GATE 8'h00
`define OFS_START 8'h04
`define OFS_CMP_FUNC 8'h08
`define OFS_PWM_SEL 8'h0c
`define OFS_CUTOFF 8'h10
`define OFS_OUT_EN 8'h14
`define OFS_INIT_LVL 8'h18
`define OFS_CONTROL 8'h1c
`define OFS_MATCH_IEN 8'h20
`define OFS_MATCH_STAT 8'h24
`define OFS_IRQ_MASK 8'h28
`define OFS_IRQ_FLAG 8'h2c
`define OFS_PRIORITY 8'h30
`define OFS_COUNTER 8'h34
`define OFS_PERIOD_A 8'h38
`define OFS_DUTY_B 8'h3c
`define OFS_DUTY_C 8'h40
`define OFS_DUTY_D 8'h44

// Field positions
`define BIT_CLK_SUPPLY 0
`define BIT_COUNT_START 0
`define BIT_CONTINUE 2
`define BIT_BUF_C 4
`define BIT_BUF_D 5
`define CUTOFF_EN_HI 7
`define CUTOFF_EN_LO 6
`define CLR_SEL_HI 7
`define CLR_SEL_LO 5
`define SRC_SEL_HI 2
`define SRC_SEL_LO 0

// Reset values
`define RST_OUT_EN 4'hf
`define RST_IRQ_MASK 1'h1
`define RST_PRIORITY 2'h3
`define RST_COMPARE 16'hffff

// Counter clear selection codes
`define CLR_NONE 3'h0
`define CLR_ON_A 3'h1

// Prescaler divide counts
`define DIV_2 5'h01
`define DIV_4 5'h03
`define DIV_8 5'h07
`define DIV_32 5'h1f

`endif

/* File: hw/pwm_timer_pkg.sv */
package pwm_timer_pkg;
   typedef enum logic [2:0] {
      SRC_FCLK = 3'h0,
      SRC_DIV2 = 3'h1,
      SRC_DIV4 = 3'h2,
      SRC_DIV8 = 3'h3,
      SRC_DIV32 = 3'h4
   } count_src_t;
   typedef logic [3:0] pin_vec_t;
endpackage

/* File: hw/sticky_flag.sv */
`timescale 1ns/1ns
module sticky_flag (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic set_i,
   input wire logic clr_i,
   // State
   output logic flag_o
);
   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

/* File: hw/pwm_channel.sv */
`timescale 1ns/1ns
module pwm_channel #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Timebase
   input wire logic running_i,
   input wire logic tick_i,
   input wire logic period_end_i,
   input wire logic [CNT_W-1:0] count_i,
   input wire logic [CNT_W-1:0] compare_i,
   input wire logic init_level_i,
   input wire logic hold_i,
   // Result
   output logic match_o,
   output logic level_o
);
   assign match_o = running_i && tick_i && (count_i == compare_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else if (!running_i) begin
         level_o <= init_level_i;
      end else if (hold_i || period_end_i) begin
         level_o <= 1'b0;
      end else if (match_o) begin
         level_o <= 1'b1;
      end
   end
endmodule

/* File: hw/timer_pwm_three_channel.sv */
// Behaviour
// - Timer logic is held in reset and unwritable while clock supply enable is 0.
// - Writing 0 to the count start bit stops the counter.
// - Interrupt mask bit at 1 blocks the timer interrupt output.
// - Writing 0 to the interrupt request flag clears the pending request.
// - Two priority bits give level 0 to 3; both set is level 3, lowest.
// - Buffer select bits at 0 keep compare C and D as independent compares.
// - PWM select bit at 1 puts outputs B, C, D under PWM control.
// - Cutoff register at zero disables forced cutoff of outputs.
// - Output enable bits are active low; 0 drives the pin.
// - Initial level bit 0 starts the output at its inactive low level.
// - Clear select 001 clears the counter on period register A match.
// - Count source 000 increments the counter every peripheral clock.
// - Each match interrupt enable gates its own match event, not the stored match flag, into the request.
// - PWM period is period register A plus one count-source cycles.
// - Output low for compare plus one cycles, then high to period end.
// - Continue bit 1 keeps counting after A match; 0 stops there.
`timescale 1ns/1ns
`include "pwm_timer_defines.svh"
module timer_pwm_three_channel #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Forced cutoff request
   input wire logic cutoff_i,
   // Pins
   output pwm_timer_pkg::pin_vec_t pwm_out_o,
   output pwm_timer_pkg::pin_vec_t pwm_oe_o,
   // Interrupt
   output logic irq_o,
   output logic [1:0] irq_priority_o
);
   import pwm_timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic clk_supply_r;
   logic start_r;
   logic continue_r;
   logic buf_c_r;
   logic buf_d_r;
   logic [2:0] pwm_sel_r;
   logic [7:0] cutoff_r;
   logic [3:0] out_en_n_r;
   logic [2:0] init_lvl_r;
   logic [2:0] clr_sel_r;
   count_src_t src_sel_r;
   logic [3:0] match_ien_r;
   logic irq_mask_r;
   logic [1:0] priority_r;
   logic [CNT_W-1:0] counter_r;
   logic [CNT_W-1:0] period_a_r;
   logic [CNT_W-1:0] duty_b_r;
   logic [CNT_W-1:0] duty_c_r;
   logic [CNT_W-1:0] duty_d_r;
   logic [4:0] presc_r;

   logic timer_rst;
   logic wr_go;
   logic [31:0] rd_nxt;
   logic tick;
   logic match_a;
   logic period_end;
   logic [3:0] match;
   logic [3:0] match_flag;
   logic [3:0] match_clr;
   logic irq_req;
   logic irq_req_set;
   logic irq_req_clr;
   logic [2:0] level;
   logic cutoff_on;

   // Timer held in reset while its clock supply is gated
   assign timer_rst = rst_i || !clk_supply_r;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   // Ack one cycle after the request, write lands on the ack edge
   assign wr_go = cyc_i && stb_i && we_i && ack_o;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (cyc_i && stb_i && !ack_o) begin
         dat_o <= rd_nxt;
      end
   end

   // Timer registers read as zero while the clock supply is off
   always_comb begin
      rd_nxt = 32'h0;
      if (adr_i == `OFS_CLOCK_GATE) begin
         rd_nxt[`BIT_CLK_SUPPLY] = clk_supply_r;
      end else if (clk_supply_r) begin
         case (adr_i)
            `OFS_START: begin
               rd_nxt[`BIT_COUNT_START] = start_r;
               rd_nxt[`BIT_CONTINUE] = continue_r;
            end
            `OFS_CMP_FUNC: begin
               rd_nxt[`BIT_BUF_C] = buf_c_r;
               rd_nxt[`BIT_BUF_D] = buf_d_r;
            end
            `OFS_PWM_SEL: rd_nxt[2:0] = pwm_sel_r;
            `OFS_CUTOFF: rd_nxt[7:0] = cutoff_r;
            `OFS_OUT_EN: rd_nxt[3:0] = out_en_n_r;
            `OFS_INIT_LVL: rd_nxt[2:0] = init_lvl_r;
            `OFS_CONTROL: begin
               rd_nxt[`CLR_SEL_HI:`CLR_SEL_LO] = clr_sel_r;
               rd_nxt[`SRC_SEL_HI:`SRC_SEL_LO] = src_sel_r;
            end
            `OFS_MATCH_IEN: rd_nxt[3:0] = match_ien_r;
            `OFS_MATCH_STAT: rd_nxt[3:0] = match_flag;
            `OFS_IRQ_MASK: rd_nxt[0] = irq_mask_r;
            `OFS_IRQ_FLAG: rd_nxt[0] = irq_req;
            `OFS_PRIORITY: rd_nxt[1:0] = priority_r;
            `OFS_COUNTER: rd_nxt[CNT_W-1:0] = counter_r;
            `OFS_PERIOD_A: rd_nxt[CNT_W-1:0] = period_a_r;
            `OFS_DUTY_B: rd_nxt[CNT_W-1:0] = duty_b_r;
            `OFS_DUTY_C: rd_nxt[CNT_W-1:0] = duty_c_r;
            `OFS_DUTY_D: rd_nxt[CNT_W-1:0] = duty_d_r;
            default: rd_nxt = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock supply gate, reachable in all states

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_supply_r <= 1'b0;
      end else if (wr_go && sel_i[0] && adr_i == `OFS_CLOCK_GATE) begin
         clk_supply_r <= dat_i[`BIT_CLK_SUPPLY];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         continue_r <= 1'b0;
         buf_c_r <= 1'b0;
         buf_d_r <= 1'b0;
         pwm_sel_r <= 3'h0;
         cutoff_r <= 8'h0;
         out_en_n_r <= `RST_OUT_EN;
         init_lvl_r <= 3'h0;
         clr_sel_r <= `CLR_NONE;
         src_sel_r <= SRC_FCLK;
         match_ien_r <= 4'h0;
         irq_mask_r <= `RST_IRQ_MASK;
         priority_r <= `RST_PRIORITY;
      end else if (wr_go && sel_i[0]) begin
         case (adr_i)
            `OFS_START: continue_r <= dat_i[`BIT_CONTINUE];
            `OFS_CMP_FUNC: begin
               buf_c_r <= dat_i[`BIT_BUF_C];
               buf_d_r <= dat_i[`BIT_BUF_D];
            end
            `OFS_PWM_SEL: pwm_sel_r <= dat_i[2:0];
            `OFS_CUTOFF: cutoff_r <= dat_i[7:0];
            `OFS_OUT_EN: out_en_n_r <= dat_i[3:0];
            `OFS_INIT_LVL: init_lvl_r <= dat_i[2:0];
            `OFS_CONTROL: begin
               clr_sel_r <= dat_i[`CLR_SEL_HI:`CLR_SEL_LO];
               src_sel_r <= count_src_t'(dat_i[`SRC_SEL_HI:`SRC_SEL_LO]);
            end
            `OFS_MATCH_IEN: match_ien_r <= dat_i[3:0];
            `OFS_IRQ_MASK: irq_mask_r <= dat_i[0];
            `OFS_PRIORITY: priority_r <= dat_i[1:0];
            default: irq_mask_r <= irq_mask_r;
         endcase
      end
   end

   // Software start/stop; hardware stops at A match when not continuing
   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         start_r <= 1'b0;
      end else if (wr_go && sel_i[0] && adr_i == `OFS_START) begin
         start_r <= dat_i[`BIT_COUNT_START];
      end else if (match_a && !continue_r) begin
         start_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count source

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         presc_r <= 5'h0;
      end else begin
         presc_r <= presc_r + 5'h1;
      end
   end

   always_comb begin
      case (src_sel_r)
         SRC_FCLK: tick = 1'b1;
         SRC_DIV2: tick = (presc_r & `DIV_2) == `DIV_2;
         SRC_DIV4: tick = (presc_r & `DIV_4) == `DIV_4;
         SRC_DIV8: tick = (presc_r & `DIV_8) == `DIV_8;
         SRC_DIV32: tick = (presc_r & `DIV_32) == `DIV_32;
         default: tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter and compare registers

   assign match_a = start_r && tick && (counter_r == period_a_r);
   assign period_end = match_a && (clr_sel_r == `CLR_ON_A);

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         counter_r <= {CNT_W{1'b0}};
      end else if (wr_go && adr_i == `OFS_COUNTER) begin
         counter_r <= merge16(counter_r, dat_i, sel_i);
      end else if (period_end) begin
         counter_r <= {CNT_W{1'b0}};
      end else if (match_a && !continue_r) begin
         counter_r <= counter_r;
      end else if (start_r && tick) begin
         counter_r <= counter_r + 1'b1;
      end
   end

   // Buffer mode moves C into A and D into B at the period match
   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         period_a_r <= `RST_COMPARE;
         duty_b_r <= `RST_COMPARE;
      end else begin
         if (wr_go && adr_i == `OFS_PERIOD_A) begin
            period_a_r <= merge16(period_a_r, dat_i, sel_i);
         end else if (match_a && buf_c_r) begin
            period_a_r <= duty_c_r;
         end
         if (wr_go && adr_i == `OFS_DUTY_B) begin
            duty_b_r <= merge16(duty_b_r, dat_i, sel_i);
         end else if (match_a && buf_d_r) begin
            duty_b_r <= duty_d_r;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         duty_c_r <= `RST_COMPARE;
         duty_d_r <= `RST_COMPARE;
      end else begin
         if (wr_go && adr_i == `OFS_DUTY_C) begin
            duty_c_r <= merge16(duty_c_r, dat_i, sel_i);
         end
         if (wr_go && adr_i == `OFS_DUTY_D) begin
            duty_d_r <= merge16(duty_d_r, dat_i, sel_i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM outputs B, C, D

   pwm_channel #(.CNT_W(CNT_W)) u_chan_b (
      .clk_i(clk_i),
      .rst_i(timer_rst),
      .running_i(start_r),
      .tick_i(tick),
      .period_end_i(period_end),
      .count_i(counter_r),
      .compare_i(duty_b_r),
      .init_level_i(init_lvl_r[0]),
      .hold_i(1'b0),
      .match_o(match[1]),
      .level_o(level[0])
   );

   pwm_channel #(.CNT_W(CNT_W)) u_chan_c (
      .clk_i(clk_i),
      .rst_i(timer_rst),
      .running_i(start_r),
      .tick_i(tick),
      .period_end_i(period_end),
      .count_i(counter_r),
      .compare_i(duty_c_r),
      .init_level_i(init_lvl_r[1]),
      .hold_i(buf_c_r),
      .match_o(match[2]),
      .level_o(level[1])
   );

   pwm_channel #(.CNT_W(CNT_W)) u_chan_d (
      .clk_i(clk_i),
      .rst_i(timer_rst),
      .running_i(start_r),
      .tick_i(tick),
      .period_end_i(period_end),
      .count_i(counter_r),
      .compare_i(duty_d_r),
      .init_level_i(init_lvl_r[2]),
      .hold_i(buf_d_r),
      .match_o(match[3]),
      .level_o(level[2])
   );

   assign match[0] = match_a;

   // Cutoff active only with a nonzero enable field
   assign cutoff_on = (cutoff_r[`CUTOFF_EN_HI:`CUTOFF_EN_LO] != 2'h0) && cutoff_i;

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         pwm_out_o <= 4'h0;
         pwm_oe_o <= 4'h0;
      end else begin
         pwm_oe_o <= ~out_en_n_r;
         if (cutoff_on) begin
            // Pin A never driven high
            pwm_out_o <= {cutoff_r[3:1], 1'b0};
         end else begin
            pwm_out_o <= {level & pwm_sel_r, 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match flags and interrupt

   for (genvar i = 0; i < 4; i++) begin : g_flag
      assign match_clr[i] = wr_go && sel_i[0] && adr_i == `OFS_MATCH_STAT && dat_i[i];
      sticky_flag u_flag (
         .clk_i(clk_i),
         .rst_i(timer_rst),
         .set_i(match[i]),
         .clr_i(match_clr[i]),
         .flag_o(match_flag[i])
      );
   end

   assign irq_req_set = |(match & match_ien_r);
   assign irq_req_clr = wr_go && sel_i[0] && adr_i == `OFS_IRQ_FLAG && !dat_i[0];

   sticky_flag u_req (
      .clk_i(clk_i),
      .rst_i(timer_rst),
      .set_i(irq_req_set),
      .clr_i(irq_req_clr),
      .flag_o(irq_req)
   );

   assign irq_o = irq_req && !irq_mask_r;

   always_ff @(posedge clk_i) begin
      if (timer_rst) begin
         irq_priority_o <= `RST_PRIORITY;
      end else begin
         irq_priority_o <= priority_r;
      end
   end

endmodule

/* File: tb/timer_pwm_three_channel_assertions.sv */
`timescale 1ns/1ns
module pwm_timer_checker #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Pins and interrupt
   input wire logic cutoff_i,
   input wire pwm_timer_pkg::pin_vec_t pwm_out_o,
   input wire pwm_timer_pkg::pin_vec_t pwm_oe_o,
   input wire logic irq_o,
   input wire logic [1:0] irq_priority_o
);
   import pwm_timer_pkg::*;
   logic [3:0] oe_want_r;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Enable value last written by the bus
   always_ff @(posedge clk_i) begin
      if (ack_o && we_i && adr_i == 8'h14)
         oe_want_r <= ~dat_i[3:0];
   end
   ////////////////////////////////////////
   ack_once_a:
      assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_cause_a:
      assert property (ack_o |-> $past(stb_i) && stb_i) else $error("ack without request");
   unmapped_zero_a:
      assert property (ack_o && !we_i && adr_i > 8'h44 |-> dat_o == 32'h0) else $error("unmapped read not zero");
   reset_quiet_a:
      assert property ($fell(rst_i) |-> pwm_out_o == 4'h0 && pwm_oe_o == 4'h0 && !irq_o && !ack_o)
      else $error("outputs busy after reset");
   prio_reset_a:
      assert property ($fell(rst_i) |-> irq_priority_o == 2'h3) else $error("priority not lowest");
   pin_a_idle_a:
      assert property (pwm_out_o[0] == 1'b0) else $error("pin A driven");
   oe_follow_a:
      assert property (ack_o && we_i && adr_i == 8'h14 && sel_i[0] |-> ##2 pwm_oe_o == oe_want_r)
      else $error("pin enables wrong");
   mask_block_a:
      assert property (ack_o && we_i && adr_i == 8'h28 && sel_i[0] && dat_i[0] |=> !irq_o [*3])
      else $error("masked interrupt seen");
   req_clear_a:
      assert property (ack_o && we_i && adr_i == 8'h2c && sel_i[0] && !dat_i[0] |=> !irq_o)
      else $error("request not cleared");
   stop_hold_a:
      assert property (ack_o && we_i && adr_i == 8'h04 && sel_i[0] && !dat_i[0] |-> ##5 $stable(pwm_out_o) [*6])
      else $error("pins move after stop");
endmodule
bind timer_pwm_three_channel pwm_timer_checker #(.CNT_W(CNT_W)) u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .cyc_i(cyc_i),
   .stb_i(stb_i),
   .we_i(we_i),
   .adr_i(adr_i),
   .sel_i(sel_i),
   .dat_i(dat_i),
   .dat_o(dat_o),
   .ack_o(ack_o),
   .cutoff_i(cutoff_i),
   .pwm_out_o(pwm_out_o),
   .pwm_oe_o(pwm_oe_o),
   .irq_o(irq_o),
   .irq_priority_o(irq_priority_o)
);

/* File: tb/tb_timer_pwm_three_channel.sv */
`timescale 1ns/1ns
module tb_timer_pwm_three_channel;
   import pwm_timer_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h3;
   logic [31:0] dat_i = 32'h0;
   logic cutoff_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   pin_vec_t pwm_out_o;
   pin_vec_t pwm_oe_o;
   logic irq_o;
   logic [1:0] irq_priority_o;
   logic [31:0] rd_q[$];
   logic [31:0] ex_q[$];
   logic [31:0] got_q[$];
   logic [31:0] rv;
   logic pb;
   event res_ev;
   int err_count = 0;
   int compares = 0;
   int seed = 32'h9e6b;
   int hb, hc, hd, rb;
   // Offset in the high byte, value in the low byte
   localparam logic [15:0] CFG [14] = '{
      16'h0800, 16'h0c07, 16'h1000,
      16'h1401, 16'h1800, 16'h1c20,
      16'h2001, 16'h3807, 16'h3c01, 16'h4003,
      16'h4405, 16'h2800, 16'h2c00, 16'h0405};

   timer_pwm_three_channel u_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .cutoff_i(cutoff_i),
      .pwm_out_o(pwm_out_o),
      .pwm_oe_o(pwm_oe_o),
      .irq_o(irq_o),
      .irq_priority_o(irq_priority_o)
   );

   initial begin
      forever #2 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic note(input logic [31:0] e, input logic [31:0] g);
      ex_q.push_back(e);
      got_q.push_back(g);
      -> res_ev;
   endtask
   // Packs irq, priority, enables and levels
   task automatic snap(input logic [10:0] e);
      note({21'h0, e}, {21'h0, irq_o, irq_priority_o, pwm_oe_o, pwm_out_o});
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0)
         cmp(rd_q.pop_front(), dat_o);
   end
   // Several notes may land in one time step
   always @(res_ev) begin
      while (ex_q.size() > 0)
         cmp(ex_q.pop_front(), got_q.pop_front());
   end
   initial begin
      #8000;
      err_count++;
      give_verdict;
   end
   ////////////////////////////////////////
   initial begin
      wt(2);
      rst_i <= 1'b0;
      wt(1);
      snap(11'h300);
      rd(8'h30, 32'h0);
      bus(1'b1, 8'h38, 32'h5);
      rd(8'h00, 32'h0);
      done("reset");
      bus(1'b1, 8'h00, 32'h1);
      rd(8'h28, 32'h1);
      rd(8'h30, 32'h3);
      rd(8'h14, 32'hf);
      rd(8'h38, 32'hffff);
      rd(8'h80, 32'h0);
      rv = $random(seed);
      bus(1'b1, 8'h44, {16'h0, rv[15:0]});
      rd(8'h44, {16'h0, rv[15:0]});
      done("registers");
      cutoff_i <= 1'b1;
      foreach (CFG[i])
         bus(1'b1, CFG[i][15:8], {24'h0, CFG[i][7:0]});
      wt(6);
      hb = 0;
      hc = 0;
      hd = 0;
      rb = 0;
      pb = pwm_out_o[1];
      repeat (32) begin
         @(posedge clk_i);
         hb += int'(pwm_out_o[1]);
         hc += int'(pwm_out_o[2]);
         hd += int'(pwm_out_o[3]);
         rb += int'(pwm_out_o[1] && !pb);
         pb = pwm_out_o[1];
      end
      note(32'd24, hb);
      note(32'd16, hc);
      note(32'd8, hd);
      note(32'd4, rb);
      done("pwm");
      bus(1'b1, 8'h04, 32'h0);
      wt(4);
      snap(11'h7e0);
      rd(8'h24, 32'hf);
      bus(1'b1, 8'h24, 32'h1);
      rd(8'h24, 32'he);
      bus(1'b1, 8'h28, 32'h1);
      snap(11'h3e0);
      bus(1'b1, 8'h28, 32'h0);
      bus(1'b1, 8'h2c, 32'h1);
      snap(11'h7e0);
      bus(1'b1, 8'h2c, 32'h0);
      snap(11'h3e0);
      done("interrupt");
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h04, 32'h1);
      wt(16);
      rd(8'h34, 32'h0);
      rd(8'h04, 32'h0);
      snap(11'h3e0);
      done("single");
      bus(1'b1, 8'h30, 32'h1);
      wt(1);
      snap(11'h1e0);
      bus(1'b1, 8'h10, 32'h4f);
      wt(1);
      snap(11'h1ee);
      cutoff_i <= 1'b0;
      wt(2);
      snap(11'h1e0);
      done("cutoff");
      bus(1'b1, 8'h00, 32'h0);
      wt(2);
      snap(11'h300);
      rd(8'h14, 32'h0);
      done("gate");
      give_verdict;
   end
endmodule
